//--- design/eip_pin_logic.sv
// Pin front end of the interrupt unit: five external requests, cascade,
// slave and pulse-width demodulation modes, and the vector hand-off to the core.
// Assumes all pin inputs are asynchronous and the core acknowledges vectors.
`timescale 1ns/100ps
module eip_pin_logic (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // Request, demodulator and timer pins, asynchronous.
  input wire logic ext_request_a,
  input wire logic ext_request_b,
  input wire logic ext_request_c,
  input wire logic ext_request_d,
  input wire logic ext_request_e,
  input wire logic pulse_demod_input,
  input wire logic timer_zero_pin,
  input wire logic timer_one_pin,
  // Low byte of the address/data bus, sampled for interrupt types.
  input wire logic [7:0] bus_data_low,
  // Configuration levels from the core.
  input wire logic [4:0] req_mask,
  input wire logic [4:0] req_level_mode,
  input wire logic cascade_a_en,
  input wire logic cascade_b_en,
  input wire logic slave_mode_en,
  input wire logic demod_en,
  input wire logic slave_irq_request,
  // Handshake with the core.
  input wire logic vector_taken,
  output logic vector_valid,
  output logic [7:0] vector_type,
  output logic [4:0] pending,
  // Acknowledge and slave request pins; enable high while driven.
  output logic cascade_ack_a,
  output logic cascade_ack_a_oe,
  output logic cascade_ack_b,
  output logic cascade_ack_b_oe,
  // Timer inputs and general-purpose view.
  output logic timer_zero_input,
  output logic timer_one_input,
  output logic gp_bit_thirtyone,
  output logic gp_bit_thirty
);

  logic [7:0] pins_async;
  logic [7:0] pins_sync;
  logic req_a_s, req_b_s, req_c_s, req_d_s, req_e_s, demod_s, tmr0_s, tmr1_s;
  logic [4:0] req_level;
  logic [4:0] req_prev;
  logic [4:0] next_req_prev;
  logic [4:0] next_pending;
  logic [4:0] live;
  logic demod_prev;
  logic next_demod_prev;
  eip_pkg::eip_state_type state;
  eip_pkg::eip_state_type next_state;
  logic [2:0] sel;
  logic [2:0] next_sel;
  logic [7:0] next_vector_type;
  logic sel_prev;
  logic next_sel_prev;
  logic [4:0] win_onehot;
  logic [2:0] win_idx;

  // Every request, demodulator and timer pin passes two flops before any logic looks at it; the bus is not synchronised.
  assign pins_async = {timer_one_pin, timer_zero_pin, pulse_demod_input, ext_request_e,
                       ext_request_d, ext_request_c, ext_request_b, ext_request_a};
  eip_sync #(.WIDTH(8)) u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pin_async(pins_async),
    .pin_sync(pins_sync)
  );
  assign {tmr1_s, tmr0_s, demod_s, req_e_s, req_d_s, req_c_s, req_b_s, req_a_s} = pins_sync;

  // Fixed vector type of each request slot.
  function automatic logic [7:0] slot_vector(input logic [2:0] idx);
    unique case (idx)
      3'h0: slot_vector = eip_pkg::VEC_A;
      3'h1: slot_vector = eip_pkg::VEC_B;
      3'h2: slot_vector = eip_pkg::VEC_C;
      3'h3: slot_vector = eip_pkg::VEC_D;
      default: slot_vector = eip_pkg::VEC_E;
    endcase
  endfunction

  // Pin roles per mode; a pin turned into an output no longer requests.
  always_comb begin
    req_level[eip_pkg::IDX_A] = req_a_s;
    req_level[eip_pkg::IDX_B] = req_b_s && !slave_mode_en;
    req_level[eip_pkg::IDX_C] = demod_en ? demod_s : (req_c_s && !cascade_a_en);
    req_level[eip_pkg::IDX_D] = req_d_s && !cascade_b_en && !slave_mode_en;
    req_level[eip_pkg::IDX_E] = demod_en ? !demod_s : req_e_s;
  end

  // Timer inputs: demodulator and its inverse, or the plain pins.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      timer_zero_input <= 1'b0;
      timer_one_input <= 1'b0;
      gp_bit_thirtyone <= 1'b0;
      gp_bit_thirty <= 1'b0;
    end else begin
      timer_zero_input <= demod_en ? demod_s : tmr0_s;
      timer_one_input <= demod_en ? !demod_s : tmr1_s;
      gp_bit_thirtyone <= demod_en ? demod_s : req_c_s;
      gp_bit_thirty <= req_e_s;
    end
  end

  // Edge-mode requests latch on rising edges; level-mode follow the pin.
  // A new edge in the cycle of its own acknowledge wins over the clear.
  always_comb begin
    next_req_prev = req_level;
    next_demod_prev = demod_s;
    live = (req_level & ~req_prev & ~req_level_mode) | (pending & ~req_level_mode);
    if (demod_en) begin
      // Request-e becomes a falling-edge flag of the demodulator input.
      live[eip_pkg::IDX_E] = (demod_prev && !demod_s) || pending[eip_pkg::IDX_E];
    end
    live = live | (req_level & req_level_mode);
    if (state == eip_pkg::EIP_VECTOR && vector_taken) begin
      live[sel] = live[sel] & (req_level[sel] & ~req_prev[sel] & ~req_level_mode[sel]);
    end
    next_pending = live;
  end

  // Lowest unmasked pending slot wins.
  always_comb begin
    win_onehot = pending & ~req_mask & (~(pending & ~req_mask) + 5'h01);
    win_idx = 3'h0;
    for (int i = 0; i < eip_pkg::NUM_REQ; i++) begin
      if (win_onehot[i]) begin
        win_idx = 3'(i);
      end
    end
  end

  // Vector sequencer: internal slots go straight out, cascade slots first
  // raise an acknowledge, slave mode waits for the select pin.
  always_comb begin
    next_state = state;
    next_sel = sel;
    next_vector_type = vector_type;
    next_sel_prev = req_b_s;
    unique case (state)
      eip_pkg::EIP_IDLE: begin
        if (slave_mode_en) begin
          // Master raises request-a, then select once the type is on the bus.
          if (req_a_s && req_b_s && !sel_prev) begin
            next_vector_type = bus_data_low;
            next_sel = 3'h0;
            next_state = eip_pkg::EIP_VECTOR;
          end
        end else if (|win_onehot) begin
          next_sel = win_idx;
          if ((win_idx == 3'h0 && cascade_a_en) || (win_idx == 3'h1 && cascade_b_en)) begin
            next_state = eip_pkg::EIP_ACK;
          end else begin
            next_vector_type = slot_vector(win_idx);
            next_state = eip_pkg::EIP_VECTOR;
          end
        end
      end
      eip_pkg::EIP_ACK: begin
        // Acknowledge stays low here and in the wait state, which samples the type the peripheral presents.
        next_state = eip_pkg::EIP_WAIT;
      end
      eip_pkg::EIP_WAIT: begin
        next_vector_type = bus_data_low;
        next_state = eip_pkg::EIP_VECTOR;
      end
      eip_pkg::EIP_VECTOR: begin
        if (vector_taken) begin
          next_state = eip_pkg::EIP_IDLE;
        end
      end
    endcase
  end

  // Register the sequencer and the request history.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state <= eip_pkg::EIP_IDLE;
      sel <= 3'h0;
      vector_type <= eip_pkg::TYPE_RESET;
      pending <= eip_pkg::REQ_RESET;
      req_prev <= eip_pkg::REQ_RESET;
      demod_prev <= 1'b0;
      sel_prev <= 1'b0;
    end else begin
      state <= next_state;
      sel <= next_sel;
      vector_type <= next_vector_type;
      pending <= next_pending;
      req_prev <= next_req_prev;
      demod_prev <= next_demod_prev;
      sel_prev <= next_sel_prev;
    end
  end

  // Pin outputs. Acknowledges are active low on the shared pins.
  assign vector_valid = (state == eip_pkg::EIP_VECTOR);
  assign cascade_ack_a_oe = cascade_a_en && !demod_en;
  assign cascade_ack_a = !(state != eip_pkg::EIP_IDLE && state != eip_pkg::EIP_VECTOR
                           && sel == 3'h0);
  assign cascade_ack_b_oe = cascade_b_en || slave_mode_en;
  assign cascade_ack_b = slave_mode_en ? slave_irq_request
                       : !(state != eip_pkg::EIP_IDLE && state != eip_pkg::EIP_VECTOR
                           && sel == 3'h1);

endmodule

//--- design/eip_sync.sv
// Two-stage synchroniser for a bus of asynchronous pin inputs.
// Assumes the inputs come from outside the clk_sys domain.
`timescale 1ns/100ps
module eip_sync #(
  parameter int WIDTH = 5
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // Pins in, synchronised levels out.
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] stage_one;

  // The first stage feeds only the second, so metastability stays contained.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      stage_one <= '0;
      pin_sync <= '0;
    end else begin
      stage_one <= pin_async;
      pin_sync <= stage_one;
    end
  end

endmodule

//--- inc/eip_pkg.sv
// Constants, vector types and state types for the external interrupt pin logic.
// Assumes one 100 MHz system clock and a synchronous active-low reset.
// Operation
// - Unmasked uncascaded request vectors to its table entry outside slave mode
// - Requests synchronised; edge or level trigger
// - Slave select means type on bus
// - Cascade on request-a makes request-c acknowledge
// - Cascade on request-b makes request-d acknowledge
// - Slave mode reuses request-d as request out
// - Demod drives timer-zero, request-c; inverse timer-one, request-e
// - Demod frees timer pins and request-e
// - Demod pin level shown in bit 31
// - Request-e flags demod falling edges
// - Software compares timers for pulse width
package eip_pkg;

  localparam int NUM_REQ = 5;
  localparam logic [4:0] REQ_RESET = 5'h00;
  localparam logic [7:0] TYPE_RESET = 8'h00;
  // Vector types of the five requests, by table position.
  localparam logic [7:0] VEC_A = 8'h0c;
  localparam logic [7:0] VEC_B = 8'h0d;
  localparam logic [7:0] VEC_C = 8'h0e;
  localparam logic [7:0] VEC_D = 8'h0f;
  localparam logic [7:0] VEC_E = 8'h10;
  localparam int GP_DEMOD_BIT = 31;
  localparam int IDX_A = 0;
  localparam int IDX_B = 1;
  localparam int IDX_C = 2;
  localparam int IDX_D = 3;
  localparam int IDX_E = 4;

  typedef enum logic [3:0] {
    EIP_IDLE = 4'h1,
    EIP_ACK = 4'h2,
    EIP_VECTOR = 4'h4,
    EIP_WAIT = 4'h8
  } eip_state_type;

endpackage

//--- verification/eip_far_model.sv
// Request sources, cascade peripherals and master controller at the pins.
// Assumes the bench pulses raise and slave_go for one clock.
`timescale 1ns/100ps
module eip_far_model (
  // Clock and bench controls.
  input wire logic clk_sys,
  input wire logic [4:0] raise,
  input wire logic slave_go,
  // Pins and handshake of the block.
  input wire logic cascade_ack_a,
  input wire logic cascade_ack_a_oe,
  input wire logic cascade_ack_b,
  input wire logic cascade_ack_b_oe,
  input wire logic vector_valid,
  input wire logic vector_taken,
  output logic [4:0] req,
  output logic [7:0] bus_data_low
);
  logic [1:0] wait_cnt;
  logic slave_act;
  logic [4:0] next_req;
  initial begin
    req = 5'h00;
    bus_data_low = 8'h00;
    wait_cnt = 2'h0;
    slave_act = 1'b0;
  end
  // Next request lines: one assignment per edge, so no bit is written twice.
  always_comb begin
    next_req = (vector_valid && vector_taken) ? 5'h00 : (req | raise);
    next_req[0] = next_req[0] || slave_go;
    next_req[1] = next_req[1] || (wait_cnt == 2'h1);
  end
  // Lines are held until the vector is taken; a released bus toggles so stale data shows.
  always @(posedge clk_sys) begin
    req <= next_req;
    slave_act <= slave_go || (slave_act && !(vector_valid && vector_taken));
    wait_cnt <= slave_go ? 2'h3 : wait_cnt - {1'b0, wait_cnt != 2'h0};
    if (cascade_ack_a_oe && !cascade_ack_a) bus_data_low <= 8'h5a;
    else if (cascade_ack_b_oe && !cascade_ack_b) bus_data_low <= 8'h6b;
    else if (slave_act) bus_data_low <= 8'h77;
    else bus_data_low <= ~bus_data_low;
  end
endmodule

//--- verification/eip_pin_props.sv
// Checker for the pin front end, bound to the ports of its top module.
// Assumes one clock and the synchronous active-low reset of the block.
`timescale 1ns/100ps
module eip_pin_props (
  // Clock, reset and controls.
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic pulse_demod_input,
  input wire logic [7:0] bus_data_low,
  input wire logic [4:0] req_mask,
  input wire logic cascade_a_en,
  input wire logic cascade_b_en,
  input wire logic slave_mode_en,
  input wire logic demod_en,
  input wire logic vector_taken,
  // Outputs of the block.
  input wire logic vector_valid,
  input wire logic [7:0] vector_type,
  input wire logic [4:0] pending,
  input wire logic cascade_ack_a,
  input wire logic cascade_ack_a_oe,
  input wire logic cascade_ack_b,
  input wire logic cascade_ack_b_oe,
  input wire logic timer_zero_input,
  input wire logic timer_one_input,
  input wire logic gp_bit_thirtyone
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // The acknowledge stays low a second cycle, then the captured byte is offered.
  sequence ack_a_tail;
    !cascade_ack_a ##1 cascade_ack_a && vector_valid && vector_type == $past(bus_data_low);
  endsequence
  sequence ack_b_tail;
    !cascade_ack_b ##1 cascade_ack_b && vector_valid && vector_type == $past(bus_data_low);
  endsequence
  chk_vec_hold: assert property (
    vector_valid && !vector_taken |=> vector_valid && $stable(vector_type))
    else $error("vector changed before it was taken");
  chk_vec_done: assert property (vector_valid && vector_taken |=> !vector_valid)
    else $error("vector still offered after it was taken");
  chk_ack_a_drive: assert property (
    $stable(cascade_a_en) && $stable(demod_en)
    |-> cascade_ack_a_oe == (cascade_a_en && !demod_en))
    else $error("request-c pin drive wrong");
  chk_ack_b_drive: assert property (
    $stable(cascade_b_en) && $stable(slave_mode_en)
    |-> cascade_ack_b_oe == (cascade_b_en || slave_mode_en))
    else $error("request-d pin drive wrong");
  chk_casc_a_seq: assert property (
    cascade_ack_a_oe && $past(cascade_ack_a_oe) && $fell(cascade_ack_a) |=> ack_a_tail)
    else $error("cascade a acknowledge sequence wrong");
  chk_casc_b_seq: assert property (
    cascade_ack_b_oe && $past(cascade_ack_b_oe) && $fell(cascade_ack_b) |=> ack_b_tail)
    else $error("cascade b acknowledge sequence wrong");
  chk_demod_route: assert property (
    (demod_en && $stable(pulse_demod_input))[*6]
    |-> timer_zero_input == pulse_demod_input && timer_one_input != pulse_demod_input
        && gp_bit_thirtyone == pulse_demod_input)
    else $error("demodulator routing wrong");
  chk_demod_fall: assert property (
    demod_en && req_mask[4] && $fell(pulse_demod_input) |-> ##[1:6] pending[4])
    else $error("falling demodulator edge not flagged");
endmodule
bind eip_pin_logic eip_pin_props i_props (.*);

//--- verification/tb_ext_irq_pin_logic.sv
// Self-checking bench for the pin front end with the far-side model.
// Assumes the checker is bound to the block by its own file.
`timescale 1ns/100ps
module tb_ext_irq_pin_logic;
  logic clk_sys, reset_n, slave_go, vector_taken, pulse_demod_input, slave_irq_request;
  logic cascade_a_en, cascade_b_en, slave_mode_en, demod_en;
  logic [4:0] raise, req_mask, req_level_mode, pending, req;
  logic [7:0] bus_data_low, vector_type;
  logic vector_valid, cascade_ack_a, cascade_ack_a_oe, cascade_ack_b, cascade_ack_b_oe;
  logic timer_zero_input, timer_one_input, gp_bit_thirtyone, gp_bit_thirty;
  logic timer_zero_pin = 1'b1;
  logic timer_one_pin = 1'b1;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  logic [7:0] vec_table [5] = '{eip_pkg::VEC_A, eip_pkg::VEC_B, eip_pkg::VEC_C,
    eip_pkg::VEC_D, eip_pkg::VEC_E};
  wire ext_request_a = req[0];
  wire ext_request_b = req[1];
  wire ext_request_c = req[2];
  wire ext_request_d = req[3];
  wire ext_request_e = req[4];
  eip_pin_logic i_dut (.*);
  eip_far_model i_far (.*);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic print_verdict();
    if (num_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Waits for the offered vector, checks it and accepts it for one clock.
  task automatic serve(input logic [7:0] exp);
    repeat (20) if (vector_valid !== 1'b1) @(negedge clk_sys);
    cmp({7'h00, vector_valid}, 8'h01);
    cmp(vector_type, exp);
    @(posedge clk_sys) vector_taken <= 1'b1;
    @(posedge clk_sys) vector_taken <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic pulse(input logic [4:0] r, input logic s);
    @(posedge clk_sys) {raise, slave_go} <= {r, s};
    @(posedge clk_sys) {raise, slave_go} <= 6'h00;
  endtask
  // A stall guard: a hang counts as a mismatch and closes the run.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      print_verdict();
    end
  end
  initial begin
    {reset_n, slave_go, vector_taken, pulse_demod_input, slave_irq_request} = 5'h00;
    {cascade_a_en, cascade_b_en, slave_mode_en, demod_en} = 4'h0;
    {raise, req_mask, req_level_mode} = 15'h0000;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
    cmp({vector_valid, 2'h0, pending}, 8'h00);
    for (int i = 0; i < 5; i++) begin
      pulse(5'h01 << i, 1'b0);
      serve(vec_table[i]);
    end
    // Plain timer pins pass straight through while demodulation is off.
    @(negedge clk_sys);
    cmp({4'h0, timer_zero_input, timer_one_input, gp_bit_thirtyone, gp_bit_thirty}, 8'h0c);
    @(posedge clk_sys) {req_mask, req_level_mode} <= 10'h108;
    pulse(5'h08, 1'b0);
    repeat (8) @(negedge clk_sys);
    cmp({vector_valid, 2'h0, pending}, 8'h08);
    // Request-d stays masked and held high, so only the cascade slot is served.
    @(posedge clk_sys) {req_mask, cascade_a_en} <= 6'h11;
    pulse(5'h01, 1'b0);
    serve(8'h5a);
    @(posedge clk_sys) {cascade_a_en, cascade_b_en} <= 2'h1;
    pulse(5'h02, 1'b0);
    serve(8'h6b);
    @(posedge clk_sys) {cascade_b_en, slave_mode_en, slave_irq_request} <= 3'h3;
    pulse(5'h00, 1'b1);
    serve(8'h77);
    @(negedge clk_sys);
    cmp({6'h00, cascade_ack_b, cascade_ack_b_oe}, 8'h03);
    @(posedge clk_sys) {slave_mode_en, demod_en, req_mask, pulse_demod_input} <= 8'h7f;
    repeat (8) @(negedge clk_sys);
    cmp({timer_zero_input, timer_one_input, gp_bit_thirtyone}, 8'h05);
    // A request-e pin edge shows on its general-purpose bit but sets no flag.
    pulse(5'h10, 1'b0);
    repeat (6) @(negedge clk_sys);
    cmp({2'h0, pending, gp_bit_thirty}, 8'h09);
    @(posedge clk_sys) pulse_demod_input <= 1'b0;
    repeat (8) @(negedge clk_sys);
    cmp({timer_zero_input, timer_one_input, gp_bit_thirtyone}, 8'h02);
    cmp({3'h0, pending} & 8'h14, 8'h14);
    print_verdict();
  end
endmodule
